// ===== design/xdiv_pkg.sv
// constants and carrier types for the divide, equivalence and sign-extend unit
package xdiv_pkg;
  localparam logic [5:0] primary_op = 6'h1f;
  localparam logic [9:0] xop_divide_unsigned = 10'h1cb;
  localparam logic [9:0] xop_equivalent = 10'h11c;
  localparam logic [9:0] xop_extend_byte = 10'h3ba;
  localparam logic [9:0] xop_extend_half = 10'h39a;
  localparam int div_steps = 32;
  localparam logic [5:0] div_count_reset = 6'h00;
  localparam logic [31:0] word_reset = 32'h0000_0000;
  localparam logic [3:0] field_reset = 4'h0;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_divide = 2'b01,
    st_done = 2'b10
  } unit_state_t;

  // condition field, msb-first: less, greater, equal, summary overflow
  typedef struct packed {
    logic less_than_bit;
    logic greater_than_bit;
    logic equal_bit;
    logic summary_bit;
  } cond_field_t;

  typedef struct packed {
    logic overflow_bit;
    logic summary_overflow_bit;
  } exc_bits_t;

  typedef struct packed {
    logic valid;
    logic [31:0] word;
    logic [4:0] target_register;
    logic record_flag;
    logic overflow_enable;
  } issue_t;

  typedef struct packed {
    unit_state_t state;
    logic [31:0] divisor;
    logic [31:0] quot;
    logic [32:0] rem;
    logic [5:0] count;
    logic [4:0] dest;
    logic record_flag;
    logic overflow_enable;
    logic div_zero;
    logic done;
    logic [31:0] result;
    logic [4:0] result_reg;
    logic cond_write;
    cond_field_t cond;
    logic exc_write;
    exc_bits_t exc;
  } unit_state_struct_t;
endpackage

// ===== design/integer_divide_logic_extend_unit.sv
// divide unsigned, equivalence and sign extension execution slice
`timescale 1ns/1ps

// Summary of operation
// - opcode 31 extended 459 divides first source by second, quotient to target
// - divide treats both operands as unsigned 32-bit, exact truncated quotient
// - divide by zero leaves target and condition bits undefined (we write zero and record it as equal)
// - divide by zero with overflow enable sets overflow and summary overflow
// - exception bits change only when overflow enable is one
// - condition field zero updated only when record flag is one
// - extended 284 writes complement of source xor second operand
// - extended 954 replicates bit 24 into bits 0 to 23
// - extended 922 replicates bit 16 into bits 0 to 15
module integer_divide_logic_extend_unit
  import xdiv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic issue_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] first_operand,
  input wire logic [31:0] second_operand,
  input wire logic summary_overflow_in,
  output logic busy,
  output logic result_valid,
  output logic [31:0] result_data,
  output logic [4:0] result_register,
  output logic cond_write,
  output cond_field_t condition_field_zero,
  output logic exc_write,
  output exc_bits_t fixed_point_exception_register
);

  // big-endian numbering: instruction bit k lives at vector index 31-k
  function automatic logic [31:0] ibit_field(input logic [31:0] w, input int first,
                                             input int last);
    logic [31:0] v;
    v = w >> (31 - last);
    return v & ((32'h1 << (last - first + 1)) - 32'h1);
  endfunction

  function automatic cond_field_t record(input logic [31:0] r, input logic so);
    cond_field_t c;
    c.less_than_bit = r[31];
    c.greater_than_bit = !r[31] && (r != word_reset);
    c.equal_bit = (r == word_reset);
    c.summary_bit = so;
    return c;
  endfunction

  unit_state_struct_t s_q, s_d;
  logic [5:0] f_primary;
  logic [9:0] f_xop;
  logic [4:0] f_target;
  logic [4:0] f_dest;
  logic f_oe;
  logic f_record;
  logic [32:0] trial;

  assign f_primary = 6'(ibit_field(instr_word, 0, 5));
  assign f_target = 5'(ibit_field(instr_word, 6, 10));
  assign f_dest = 5'(ibit_field(instr_word, 11, 15));
  assign f_oe = instr_word[31 - 21];
  assign f_record = instr_word[31 - 31];
  assign f_xop = 10'(ibit_field(instr_word, 21, 30));
  assign trial = {s_q.rem[31:0], s_q.quot[31]} - {1'b0, s_q.divisor};

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] r;
    logic so_now;
    r = word_reset;
    so_now = summary_overflow_in;
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.cond_write = 1'b0;
    s_d.exc_write = 1'b0;
    case (s_q.state)
      st_idle: begin
        if (issue_valid && f_primary == primary_op) begin
          if (f_xop[8:0] == xop_divide_unsigned[8:0]) begin
            // divide uses a 9-bit extended code with the overflow enable in bit 21
            s_d.state = st_divide;
            s_d.divisor = second_operand;
            s_d.quot = first_operand;
            s_d.rem = 33'h0_0000_0000;
            s_d.count = div_count_reset;
            s_d.dest = f_target;
            s_d.record_flag = f_record;
            s_d.overflow_enable = f_oe;
            s_d.div_zero = (second_operand == word_reset);
          end else if (f_xop == xop_equivalent || f_xop == xop_extend_byte ||
                       f_xop == xop_extend_half) begin
            if (f_xop == xop_equivalent) begin
              r = ~(first_operand ^ second_operand);
            end else if (f_xop == xop_extend_byte) begin
              r = {{24{first_operand[31 - 24]}}, first_operand[7:0]};
            end else begin
              r = {{16{first_operand[31 - 16]}}, first_operand[15:0]};
            end
            s_d.done = 1'b1;
            s_d.result = r;
            s_d.result_reg = f_dest;
            s_d.cond_write = f_record;
            if (f_record) begin
              s_d.cond = record(r, so_now);
            end
          end
        end
      end
      st_divide: begin
        // restoring divide, one quotient bit per cycle
        if (!trial[32]) begin
          s_d.rem = trial;
        end else begin
          s_d.rem = {s_q.rem[31:0], s_q.quot[31]};
        end
        s_d.quot = {s_q.quot[30:0], !trial[32]};
        s_d.count = s_q.count + 6'h01;
        if (s_q.count == 6'(div_steps - 1)) begin
          s_d.state = st_done;
        end
      end
      st_done: begin
        r = s_q.div_zero ? word_reset : s_q.quot;
        if (s_q.overflow_enable) begin
          s_d.exc_write = 1'b1;
          s_d.exc.overflow_bit = s_q.div_zero;
          s_d.exc.summary_overflow_bit = summary_overflow_in | s_q.div_zero;
          so_now = summary_overflow_in | s_q.div_zero;
        end
        s_d.done = 1'b1;
        s_d.result = r;
        s_d.result_reg = s_q.dest;
        s_d.cond_write = s_q.record_flag;
        if (s_q.record_flag) begin
          s_d.cond = record(r, so_now);
        end
        s_d.state = st_idle;
      end
      default: s_d.state = st_idle;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = (s_q.state != st_idle);
  assign result_valid = s_q.done;
  assign result_data = s_q.result;
  assign result_register = s_q.result_reg;
  assign cond_write = s_q.cond_write;
  assign condition_field_zero = s_q.cond;
  assign exc_write = s_q.exc_write;
  assign fixed_point_exception_register = s_q.exc;

  //////////////////////////////////////////////////////////////////////////////
  chk_divzero_overflow: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.state == st_done && s_q.div_zero && s_q.overflow_enable) |=>
    (exc_write && fixed_point_exception_register == 2'b11))
    else $error("divide by zero did not set overflow bits");
  chk_overflow_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.state == st_done && s_q.overflow_enable && !s_q.div_zero) |=>
    (exc_write && !fixed_point_exception_register.overflow_bit))
    else $error("overflow set without divide by zero");
  chk_exc_needs_oe: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.state == st_done && !s_q.overflow_enable) |=> !exc_write)
    else $error("exception bits written without overflow enable");
  chk_exc_divide_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.state != st_done) |=> !exc_write)
    else $error("exception bits written outside divide finish");
  chk_cond_needs_record: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.state == st_done) |=> (cond_write == $past(s_q.record_flag)))
    else $error("condition write does not follow record flag");
  chk_divzero_result: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.state == st_done && s_q.div_zero) |=>
    (result_valid && result_data == word_reset))
    else $error("divide by zero result not cleared");
  chk_divide_quotient: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.state == st_idle && issue_valid && f_primary == primary_op &&
     f_xop[8:0] == xop_divide_unsigned[8:0] && second_operand != word_reset) |->
    ##34 (result_valid && result_data ==
          $past(first_operand, 34) / $past(second_operand, 34)))
    else $error("unsigned quotient wrong or late");
  chk_divide_target: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.state == st_idle && issue_valid && f_primary == primary_op &&
     f_xop[8:0] == xop_divide_unsigned[8:0]) |->
    ##34 (result_valid && result_register == $past(f_target, 34)))
    else $error("divide result went to wrong register");
  chk_busy_no_result: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.state == st_divide) |=> !result_valid)
    else $error("result appeared during divide");
  chk_eqv_result: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.state == st_idle && issue_valid && f_primary == primary_op &&
     f_xop == xop_equivalent) |=>
    (result_valid && result_data == ~($past(first_operand) ^ $past(second_operand))))
    else $error("equivalence result wrong");
  chk_logic_target: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.state == st_idle && issue_valid && f_primary == primary_op &&
     (f_xop == xop_equivalent || f_xop == xop_extend_byte || f_xop == xop_extend_half)) |=>
    (result_valid && result_register == $past(f_dest)))
    else $error("logic result went to wrong register");
  chk_extb_result: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.state == st_idle && issue_valid && f_primary == primary_op &&
     f_xop == xop_extend_byte) |=>
    (result_data == 32'($signed($past(first_operand[7:0])))))
    else $error("byte sign extension wrong");
  chk_exth_result: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (s_q.state == st_idle && issue_valid && f_primary == primary_op &&
     f_xop == xop_extend_half) |=>
    (result_data == 32'($signed($past(first_operand[15:0])))))
    else $error("halfword sign extension wrong");
  chk_record_compare: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cond_write |-> (condition_field_zero.equal_bit == (result_data == word_reset) &&
                    condition_field_zero.less_than_bit == result_data[31]))
    else $error("recorded condition disagrees with result");
  chk_cond_greater: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cond_write |-> (condition_field_zero.greater_than_bit ==
                    (!result_data[31] && result_data != word_reset)))
    else $error("greater-than bit disagrees with result");
  chk_cond_summary: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cond_write |-> (condition_field_zero.summary_bit == ($past(summary_overflow_in) |
                    (exc_write & fixed_point_exception_register.overflow_bit))))
    else $error("recorded summary bit wrong");
endmodule

// ===== sim/core_side_model.sv
// core-side model: holds the summary overflow bit fed back to the unit
`timescale 1ns/1ps
module core_side_model
  import xdiv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic exc_write,
  input exc_bits_t fixed_point_exception_register,
  output logic summary_overflow_q
);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      summary_overflow_q <= 1'b0;
    end else if (exc_write) begin
      summary_overflow_q <= fixed_point_exception_register.summary_overflow_bit;
    end
  end
endmodule

// ===== sim/integer_divide_logic_extend_unit_bench.sv
// self-checking bench for the divide, equivalence and sign-extend unit
`timescale 1ns/1ps
module integer_divide_logic_extend_unit_bench;
  import xdiv_pkg::*;
  typedef struct packed {
    logic [31:0] data;
    logic [4:0] dest;
    logic cw;
    cond_field_t cond;
    logic ew;
    exc_bits_t exc;
  } note_t;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic issue_valid = 1'b0;
  logic [31:0] instr_word = 32'h0;
  logic [31:0] first_operand = 32'h0;
  logic [31:0] second_operand = 32'h0;
  logic summary_overflow_in, busy, result_valid, cond_write, exc_write;
  logic [31:0] result_data;
  logic [4:0] result_register;
  cond_field_t condition_field_zero;
  exc_bits_t fixed_point_exception_register;
  note_t exp_q[$];
  note_t got;
  note_t want;
  logic exp_so = 1'b0;
  logic [9:0] ops [4] = '{xop_divide_unsigned, xop_equivalent, xop_extend_byte, xop_extend_half};
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 24;

  integer_divide_logic_extend_unit dut (.ref_clk, .rst_b, .issue_valid, .instr_word,
    .first_operand, .second_operand, .summary_overflow_in, .busy, .result_valid,
    .result_data, .result_register, .cond_write, .condition_field_zero, .exc_write,
    .fixed_point_exception_register);
  core_side_model peer (.ref_clk, .rst_b, .exc_write, .fixed_point_exception_register,
    .summary_overflow_q(summary_overflow_in));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // results are registered, so they are read at the falling edge
  always @(negedge ref_clk) begin
    if (rst_b && result_valid === 1'b1) begin
      got = {result_data, result_register, cond_write, cond_write ? condition_field_zero : 4'h0,
             exc_write, exc_write ? fixed_point_exception_register : 2'h0};
      want = (exp_q.size() > 0) ? exp_q.pop_front() : ~got;
      checks++;
      if (got !== want) begin
        num_errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, want);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic issue(input logic [9:0] xop, input logic [31:0] a, input logic [31:0] b,
                       input logic rec, input logic oe, input logic taken);
    note_t e;
    logic [4:0] dst;
    logic [31:0] r;
    logic dz;
    logic dv;
    dst = 5'($random(seed));
    dv = (xop == xop_divide_unsigned);
    dz = dv && (b == 32'h0);
    case (xop)
      xop_divide_unsigned: r = dz ? 32'h0 : a / b;
      xop_equivalent: r = ~(a ^ b);
      xop_extend_byte: r = {{24{a[7]}}, a[7:0]};
      default: r = {{16{a[15]}}, a[15:0]};
    endcase
    if (taken && dv && oe) exp_so = exp_so | dz;
    e.data = r;
    e.dest = dst;
    e.cw = rec;
    e.ew = dv && oe;
    e.cond = rec ? {$signed(r) < 0, $signed(r) > 0, r == 32'h0, exp_so} : 4'h0;
    e.exc = e.ew ? {dz, exp_so} : 2'h0;
    if (taken) exp_q.push_back(e);
    @(posedge ref_clk);
    issue_valid <= 1'b1;
    first_operand <= a;
    second_operand <= b;
    instr_word <= dv ? {primary_op, dst, 5'h3, 5'h4, oe, xop[8:0], rec}
                     : {primary_op, 5'h3, dst, 5'h4, xop, rec};
    @(posedge ref_clk);
    issue_valid <= 1'b0;
  endtask

  // queue must empty and the unit must be idle again
  task automatic drain();
    for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(posedge ref_clk);
    @(negedge ref_clk);
    checks++;
    if (exp_q.size() != 0 || busy !== 1'b0) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, {exp_q.size(), busy}, 33'h0);
      exp_q.delete();
    end
    repeat (2) @(posedge ref_clk);
  endtask

  initial begin
    logic [31:0] b;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    issue(xop_divide_unsigned, 32'hffff_ffff, 32'h1, 1'b1, 1'b0, 1'b1);
    drain();
    issue(xop_divide_unsigned, 32'h1234, 32'h0, 1'b1, 1'b0, 1'b1);
    drain();
    issue(xop_divide_unsigned, 32'h8000_0000, 32'h0, 1'b1, 1'b1, 1'b1);
    drain();
    $display("test corners done");
    issue(xop_divide_unsigned, 32'h64, 32'h7, 1'b1, 1'b1, 1'b1);
    @(negedge ref_clk);
    checks++;
    if (busy !== 1'b1) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, busy, 1'b1);
    end
    issue(xop_equivalent, 32'h5, 32'h6, 1'b1, 1'b0, 1'b0);
    drain();
    issue(10'h001, 32'h5, 32'h6, 1'b1, 1'b0, 1'b0);
    drain();
    $display("test refused done");
    for (int n = 0; n < 60; n++) begin
      b = (($random(seed) & 7) == 0) ? 32'h0 : $random(seed);
      issue(ops[$random(seed) & 3], $random(seed), b, 1'($random(seed)),
            1'($random(seed)), 1'b1);
      drain();
    end
    $display("test random done");
    tally_and_finish();
  end
endmodule
